/* File: include/crb_consts.vh */
// Purpose: Constants for the coefficient memory block addressing logic
// Assumes: Included by bare name; definitions only
// Notes:   Block and word fields form the six-bit word address
`ifndef CRB_CONSTS_VH
`define CRB_CONSTS_VH

`define CRB_WORDS          40
`define CRB_BLOCKS         5
`define CRB_WORDS_PER_BLK  8
`define CRB_ADDR_W         6
`define CRB_BLK_W          3
`define CRB_IDX_W          3
`define CRB_IDX_FIRST      3'h7
`define CRB_IDX_LAST       3'h0
`define CRB_IDX_ONE        3'h1
`define CRB_BLK_IMPEDANCE  3'h0
`define CRB_BLK_ECHO       3'h1
`define CRB_BLK_IN_GAIN    3'h2
`define CRB_BLK_TX         3'h3
`define CRB_BLK_RX         3'h4
`define CRB_BLK_MAX        3'h4
`define CRB_IDX_HALF_BIT   2

`endif

/* File: core/crb_word_mem.v */
// Purpose: Coefficient storage array, one write port and one read port
// Assumes: Single clock; read data registered one cycle after address
// Notes:   Addresses at or above the word count are ignored on write and read as zero
`timescale 1ns/100ps
`default_nettype none
`include "crb_consts.vh"

module crb_word_mem #(
   parameter DATA_W = 16,
   parameter WORDS  = `CRB_WORDS
) (
   input  wire                   ref_clk,
   input  wire                   wr_en,
   input  wire [`CRB_ADDR_W-1:0] wr_addr,
   input  wire [DATA_W-1:0]      wr_data,
   input  wire [`CRB_ADDR_W-1:0] rd_addr,
   output reg  [DATA_W-1:0]      rd_data
);
   reg [DATA_W-1:0] mem_reg [0:WORDS-1];

   // Write port, guarded against the unused top addresses
   always @(posedge ref_clk) begin
      if (wr_en && (wr_addr < WORDS))
         mem_reg[wr_addr] <= wr_data;
   end

   // Registered read port
   always @(posedge ref_clk) begin
      if (rd_addr < WORDS)
         rd_data <= mem_reg[rd_addr];
      else
         rd_data <= {DATA_W{1'b0}};
   end
endmodule
`default_nettype wire

/* File: core/crb_block_addr.v */
// Purpose: Block addressing for the per-channel coefficient memory
// Assumes: Commands arrive from command framing logic on ref_clk; one word per beat
// Notes:   A command names a block; the eight words are walked from index 7 down to 0
//
// How it works
// - Memory holds forty words as five blocks of eight consecutive words.
// - Word address is block number in top three bits, index in bottom three.
// - Command carries only the block; all eight words follow with no addressing.
// - Word index starts at 111 and counts down to 000, highest first.
// - Blocks: impedance, echo, input gain, rx corr a plus tx gain, rx corr b plus rx gain.
// - Selecting block 100 for receive gain also reaches receive correction b words.
`timescale 1ns/100ps
`default_nettype none
`include "crb_consts.vh"

module crb_block_addr #(
   parameter DATA_W = 16
) (
   input  wire                   ref_clk,
   input  wire                   rst_n,
   input  wire                   cmd_valid,
   input  wire                   cmd_write,
   input  wire [`CRB_BLK_W-1:0]  cmd_block,
   output wire                   cmd_ready,
   output reg                    cmd_error,
   input  wire                   wr_valid,
   input  wire [DATA_W-1:0]      wr_data,
   output wire                   wr_ready,
   output reg                    rd_valid,
   output reg  [DATA_W-1:0]      rd_data,
   input  wire                   rd_ready,
   output reg  [`CRB_ADDR_W-1:0] word_addr,
   output wire                   busy,
   output reg                    done,
   output reg  [4:0]             blk_func
);
   // One-hot states
   localparam [3:0] ST_IDLE  = 4'h1;
   localparam [3:0] ST_WRITE = 4'h2;
   localparam [3:0] ST_FETCH = 4'h4;
   localparam [3:0] ST_SEND  = 4'h8;

   reg [3:0]             state_reg,   state_next;
   reg [`CRB_BLK_W-1:0]  blk_reg,     blk_next;
   reg [`CRB_IDX_W-1:0]  idx_reg,     idx_next;
   reg                   err_next;
   reg                   done_next;
   reg                   rdv_next;
   reg [DATA_W-1:0]      rdd_next;
   wire [`CRB_ADDR_W-1:0] cur_addr;
   wire                  mem_we;
   wire [DATA_W-1:0]     mem_q;
   wire                  blk_ok;
   wire                  last_word;

   // Address is block over index
   assign cur_addr  = {blk_reg, idx_reg};
   assign blk_ok    = (cmd_block <= `CRB_BLK_MAX);
   assign last_word = (idx_reg == `CRB_IDX_LAST);
   assign cmd_ready = state_reg[0];
   assign busy      = ~state_reg[0];
   assign wr_ready  = state_reg[1];
   assign mem_we    = state_reg[1] & wr_valid;

   crb_word_mem #(
      .DATA_W (DATA_W),
      .WORDS  (`CRB_WORDS)
   ) u_mem (
      .ref_clk (ref_clk),
      .wr_en   (mem_we),
      .wr_addr (cur_addr),
      .wr_data (wr_data),
      .rd_addr (cur_addr),
      .rd_data (mem_q)
   );

   // Sequencer: count the word index down through the selected block
   always @* begin
      state_next = state_reg;
      blk_next   = blk_reg;
      idx_next   = idx_reg;
      err_next   = 1'b0;
      done_next  = 1'b0;
      rdv_next   = rd_valid;
      rdd_next   = rd_data;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_valid) begin
               if (blk_ok) begin
                  blk_next = cmd_block;
                  idx_next = `CRB_IDX_FIRST;
                  state_next = cmd_write ? ST_WRITE : ST_FETCH;
               end else begin
                  err_next = 1'b1;
               end
            end
         end
         ST_WRITE: begin
            if (wr_valid) begin
               idx_next = idx_reg - `CRB_IDX_ONE;
               if (last_word) begin
                  state_next = ST_IDLE;
                  done_next  = 1'b1;
               end
            end
         end
         ST_FETCH: begin
            // Memory read of cur_addr completes this cycle
            state_next = ST_SEND;
         end
         ST_SEND: begin
            if (!rd_valid) begin
               rdv_next = 1'b1;
               rdd_next = mem_q;
            end else if (rd_ready) begin
               rdv_next = 1'b0;
               if (last_word) begin
                  state_next = ST_IDLE;
                  done_next  = 1'b1;
               end else begin
                  idx_next   = idx_reg - `CRB_IDX_ONE;
                  state_next = ST_FETCH;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
            rdv_next   = 1'b0;
         end
      endcase
   end

   // State and output registers
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         blk_reg   <= `CRB_BLK_IMPEDANCE;
         idx_reg   <= `CRB_IDX_FIRST;
         cmd_error <= 1'b0;
         done      <= 1'b0;
         rd_valid  <= 1'b0;
         rd_data   <= {DATA_W{1'b0}};
         word_addr <= {`CRB_ADDR_W{1'b0}};
      end else begin
         state_reg <= state_next;
         blk_reg   <= blk_next;
         idx_reg   <= idx_next;
         cmd_error <= err_next;
         done      <= done_next;
         rd_valid  <= rdv_next;
         rd_data   <= rdd_next;
         word_addr <= {blk_next, idx_next};
      end
   end

   // Function decode of the word being addressed:
   // bit0 impedance, bit1 echo, bit2 input gain, bit3 rx corr a/tx gain half,
   // bit4 rx corr b/rx gain; block 4 covers both of its functions at once
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         blk_func <= 5'h00;
      end else if (state_next == ST_IDLE) begin
         blk_func <= 5'h00;
      end else begin
         case (blk_next)
            `CRB_BLK_IMPEDANCE: blk_func <= 5'h01;
            `CRB_BLK_ECHO:      blk_func <= 5'h02;
            `CRB_BLK_IN_GAIN:   blk_func <= 5'h04;
            `CRB_BLK_TX:        blk_func <= 5'h08;
            `CRB_BLK_RX:        blk_func <= 5'h10;
            default:            blk_func <= 5'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: tb/crb_rd_sink.sv */
// Purpose: Far-side reader that takes read words from the block
// Assumes: Changes only on the falling edge
// Notes:   Stalls at random when asked, else accepts every word
`timescale 1ns/100ps
`default_nettype none
module crb_rd_sink (
   input  wire logic ref_clk,
   input  wire logic stall_en,
   output logic      rd_ready
);
   integer seed = 32'h64c1;
   initial rd_ready = 1'b0;
   // Prompt or slow acceptance of words in delivered order
   always @(negedge ref_clk) rd_ready <= stall_en ? $random(seed) : 1'b1;
endmodule
`default_nettype wire

/* File: tb/crb_block_addr_monitor.sv */
// Purpose: Port checker for coefficient block addressing
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module crb_block_addr_monitor #(parameter DATA_W = 16) (
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic              cmd_valid,
   input wire logic              cmd_write,
   input wire logic [2:0]        cmd_block,
   input wire logic              cmd_ready,
   input wire logic              cmd_error,
   input wire logic              wr_valid,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic              wr_ready,
   input wire logic              rd_valid,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic              rd_ready,
   input wire logic [5:0]        word_addr,
   input wire logic              busy,
   input wire logic              done,
   input wire logic [4:0]        blk_func
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Read command taken, then first word offered three edges later
   sequence s_rd_take; cmd_valid && cmd_ready && !cmd_write && cmd_block <= 3'h4; endsequence
   sequence s_word_out; ##3 rd_valid; endsequence
   a_bad_block: assert property (cmd_valid && cmd_ready && cmd_block > 3'h4 |=> cmd_error && !busy)
      else $error("bad block not refused");
   a_start_index: assert property (cmd_valid && cmd_ready && cmd_block <= 3'h4 |=>
      busy && word_addr == {$past(cmd_block), 3'h7}) else $error("walk start wrong");
   a_write_step: assert property (wr_valid && wr_ready && word_addr[2:0] != 3'h0 |=>
      word_addr == $past(word_addr) - 6'h1) else $error("index not stepping down");
   a_last_done: assert property (wr_valid && wr_ready && word_addr[2:0] == 3'h0 |=>
      done && cmd_ready) else $error("no done after last word");
   a_func_map: assert property (busy |-> blk_func == (5'h1 << word_addr[5:3]))
      else $error("block function wrong");
   a_ready_idle: assert property (cmd_ready == !busy) else $error("ready not idle");
   a_read_first: assert property (s_rd_take |-> s_word_out)
      else $error("read word late");
   a_read_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read word dropped");
endmodule
bind crb_block_addr crb_block_addr_monitor #(.DATA_W(DATA_W)) u_mon (.*);
`default_nettype wire

/* File: tb/test_coef_ram_block_addressing.sv */
// Purpose: Self-checking bench for coefficient block addressing
// Assumes: Inputs driven on the falling edge
// Notes:   Writes each block at random pace, reads it back through a stalling reader
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %0t mismatch", $time); end end
module test_coef_ram_block_addressing;
   logic        ref_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
   logic [2:0]  cmd_block = 3'h0;
   logic        wr_valid = 1'b0, rd_ready, cmd_ready, cmd_error, wr_ready, rd_valid, busy, done;
   logic [15:0] wr_data = 16'h0, rd_data;
   logic [5:0]  word_addr;
   logic [4:0]  blk_func;
   logic [15:0] exp_mem [0:39];
   logic [15:0] exp_q [$];
   integer      seed = 32'h64c1, miscompares = 0, checks_done = 0, n, b, k;
   crb_block_addr dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_block(cmd_block), .cmd_ready(cmd_ready),
      .cmd_error(cmd_error), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .word_addr(word_addr),
      .busy(busy), .done(done), .blk_func(blk_func));
   crb_rd_sink u_sink (.ref_clk(ref_clk), .stall_en(1'b1), .rd_ready(rd_ready));
   initial forever #4 ref_clk = ~ref_clk;
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Issue one command; the block is idle so it is taken at the next edge
   task cmd(input logic w, input logic [2:0] blk);
      @(negedge ref_clk);
      cmd_valid = 1'b1; cmd_write = w; cmd_block = blk;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
   endtask
   // Compare each delivered word against the oldest note
   always @(posedge ref_clk) if (rd_valid && rd_ready) `CHK(rd_data, exp_q.pop_front())
   initial begin
      #(8 * 20000); miscompares++; summarize;
   end
   initial begin
      repeat (16) @(negedge ref_clk);
      rst_n = 1'b1;
      for (b = 0; b < 5; b++) begin
         cmd(1'b1, b[2:0]);
         `CHK(blk_func, 5'h1 << b)
         for (k = 7; k >= 0; k--) begin
            wr_valid = 1'b0;
            while (!wr_valid) begin
               wr_valid = $random(seed); wr_data = $random(seed);
               if (!wr_valid) @(negedge ref_clk);
            end
            `CHK(word_addr, {b[2:0], k[2:0]})
            exp_mem[b * 8 + k] = wr_data;
            exp_q.push_back(wr_data);
            @(negedge ref_clk);
         end
         wr_valid = 1'b0;
         `CHK(done, 1'b1)
         cmd(1'b0, b[2:0]);
         n = 0;
         while (!done && n < 400) begin @(negedge ref_clk); n++; end
         `CHK(exp_q.size(), 0)
         $display("block %0d done", b);
      end
      for (b = 5; b < 8; b++) begin
         cmd(1'b1, b[2:0]);
         `CHK({cmd_error, busy}, 2'b10)
      end
      $display("refusal test done");
      summarize;
   end
endmodule
`default_nettype wire
